/* File: verif/hrx_link_asserts.sv */
// concurrent checks on the link joining the dispatch and control ends
`timescale 1ns/10ps
module hrx_link_asserts #(
  parameter int AVW = 24
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic auxPending,
  input wire logic popReq,
  input wire logic [31:0] popData,
  input wire logic detIrq,
  input wire logic [1:0] detVer,
  input wire logic detAck,
  input wire logic dec14En,
  input wire logic dec22En,
  input wire logic decRst,
  input wire logic egrValid,
  input wire logic [AVW-1:0] egrData,
  input wire logic egrLast,
  input wire logic ingValid,
  input wire logic [AVW-1:0] ingData,
  input wire logic ingLast
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------
  // detection and switching
  // ----------------------------------------------------------
  ver_legal_a: assert property (detIrq |-> detVer inside {2'h1, 2'h2})
    else $error("detected version out of range");
  irq_sticky_a: assert property (detIrq && !detAck |=> detIrq)
    else $error("detect interrupt dropped without ack");
  irq_on_change_a: assert property ($changed(detVer) |-> detIrq)
    else $error("version changed without interrupt");
  one_decryptor_a: assert property (!(dec14En && dec22En))
    else $error("both decryptors enabled");
  ack_resets_a: assert property (detAck |=> decRst && !dec14En
    && !dec22En)
    else $error("ack not followed by decryptor reset");
  rst_then_en_a: assert property (decRst |=> (dec14En || dec22En))
    else $error("no decryptor enabled after reset");
  en_matches_a: assert property ($rose(dec14En) || $rose(dec22En)
    |-> {dec22En, dec14En} == detVer)
    else $error("enabled decryptor differs from detected version");
  // ----------------------------------------------------------
  // data paths
  // ----------------------------------------------------------
  ing_follows_a: assert property (ingValid |-> $past(egrValid))
    else $error("ingress word without egress word");
  drain_bound_a: assert property (auxPending |-> ##[0:20] popReq)
    else $error("queued packet not drained");
  pop_hold_a: assert property (!popReq |=> $stable(popData))
    else $error("popped word changed without a pop");
  cov_irq: cover property ($rose(detIrq));
  cov_ing: cover property (ingValid && ingLast);
  cov_pop: cover property (popReq ##2 popReq);
  cov_rst: cover property (decRst);
endmodule // hrx_link_asserts

/* File: verif/tb.sv */
// self-checking bench for the dispatch and control ends joined by the link
`timescale 1ns/10ps
module tb;
  import hrx_pkg::*;
  logic ref_clk = 0;
  logic reset = 1;
  logic pktValid = 0;
  logic pktSop = 0;
  logic [7:0] pktByte = 8'h00;
  logic ddcValid = 0;
  logic [6:0] ddcSlave = 7'h00;
  logic [7:0] ddcOffset = 8'h00;
  logic avValid = 0;
  logic [23:0] avData = 24'h000000;
  logic avLast = 0;
  logic [23:0] decKey = 24'h000000;
  logic audValid, audEnd, audBad, vidValid, vidLast, eccErr, queueOvf;
  logic swValid, swHeader, swInfoFrame;
  logic [31:0] audWord, swWord;
  logic [23:0] vidData;
  logic [1:0] activeVer;
  logic [1:0] curVer = 2'h0;
  logic expKind = 0;
  logic prevIrq = 0;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  int eccSeen = 0, eccExp = 0, endSeen = 0, endExp = 0;
  int irqSeen = 0, irqExp = 0;
  logic [32:0] audQ[$], swQ[$], vidQ[$];
  logic badQ[$];
  always #12.5 ref_clk = ~ref_clk;
  hrx_link_if #(.AVW(24)) lnk ();
  hrx_dispatch_end #(.PROT_MODE(HRX_PROT_BOTH), .AVW(24), .AW(6))
    hrx_dispatch_end_inst (.ref_clk(ref_clk), .reset(reset),
    .pktValid(pktValid), .pktSop(pktSop), .pktByte(pktByte),
    .ddcValid(ddcValid), .ddcSlave(ddcSlave), .ddcOffset(ddcOffset),
    .avValid(avValid), .avData(avData), .avLast(avLast),
    .audValid(audValid), .audWord(audWord), .audEnd(audEnd), .audBad(audBad),
    .vidValid(vidValid), .vidData(vidData), .vidLast(vidLast),
    .eccErr(eccErr), .queueOvf(queueOvf), .lnk(lnk.dev));
  hrx_control_end #(.PROT_MODE(HRX_PROT_BOTH), .AVW(24))
    hrx_control_end_inst (.ref_clk(ref_clk), .reset(reset), .decKey(decKey),
    .swValid(swValid), .swWord(swWord), .swHeader(swHeader),
    .swInfoFrame(swInfoFrame), .activeVer(activeVer), .lnk(lnk.host));
  hrx_link_asserts #(.AVW(24)) hrx_link_asserts_inst (.ref_clk(ref_clk),
    .reset(reset), .auxPending(lnk.auxPending), .popReq(lnk.popReq),
    .popData(lnk.popData), .detIrq(lnk.detIrq), .detVer(lnk.detVer),
    .detAck(lnk.detAck), .dec14En(lnk.dec14En), .dec22En(lnk.dec22En),
    .decRst(lnk.decRst), .egrValid(lnk.egrValid), .egrData(lnk.egrData),
    .egrLast(lnk.egrLast), .ingValid(lnk.ingValid), .ingData(lnk.ingData),
    .ingLast(lnk.ingLast));
  // ----------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------
  task automatic check(string what, logic [32:0] seen, logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // lsb-first parity register, seeded 0 per header or subpacket
  function automatic logic [7:0] ecc8(logic [55:0] v, int n);
    logic [7:0] e;
    logic fb;
    e = 8'h00;
    for (int i = 0; i < n * 8; i++) begin
      fb = v[i] ^ e[0];
      e = (e >> 1) ^ (fb ? ECC_POLY : 8'h00);
    end
    return e;
  endfunction
  // ----------------------------------------------------------
  // output monitor against the queued model
  // ----------------------------------------------------------
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      close_out();
    end
    if (!reset) begin
      if (audValid === 1'b1) begin
        check("audWord", {1'b0, audWord},
          audQ.size() ? audQ.pop_front() : '1);
      end
      if (audEnd === 1'b1) begin
        check("audBad", {32'h0, audBad},
          badQ.size() ? {32'h0, badQ.pop_front()} : '1);
      end
      if (swValid === 1'b1) begin
        if (swHeader === 1'b1 && swQ.size()) begin
          expKind = swQ[0][24];
        end
        check("swWord", {swHeader, swWord},
          swQ.size() ? swQ.pop_front() : '1);
        check("swInfoFrame", swInfoFrame, expKind);
      end
      if (vidValid === 1'b1) begin
        check("vidData", {vidLast, vidData},
          vidQ.size() ? vidQ.pop_front() : '1);
      end
      if (queueOvf === 1'b1) begin
        check("queueOvf", queueOvf, 0);
      end
      eccSeen += (eccErr === 1'b1);
      endSeen += (audEnd === 1'b1);
      irqSeen += (lnk.detIrq === 1'b1 && !prevIrq);
      prevIrq = (lnk.detIrq === 1'b1);
    end
  end
  // ----------------------------------------------------------
  // stimulus tasks
  // ----------------------------------------------------------
  task automatic send_pkt(logic [7:0] typ, bit bad);
    logic [7:0] b[36];
    logic [7:0] d[28];
    logic [55:0] v;
    logic [31:0] w[8];
    logic kind;
    logic aud;
    kind = typ >= INFOFRAME_BASE && typ <= INFOFRAME_BASE + INFOFRAME_MAX;
    aud = typ inside {TYPE_ACR, TYPE_AUDIO, TYPE_ONEBIT, TYPE_DST,
                      TYPE_HBR};
    b[0] = typ;
    b[1] = 8'($urandom);
    b[2] = 8'($urandom);
    b[3] = ecc8({32'h0, b[2], b[1], b[0]}, 3) ^ {7'h0, bad};
    for (int s = 0; s < 4; s++) begin
      for (int j = 0; j < 7; j++) begin
        d[7*s+j] = 8'($urandom);
        b[4+8*s+j] = d[7*s+j];
        v[8*j+:8] = d[7*s+j];
      end
      b[11+8*s] = ecc8(v, 7);
    end
    w[0] = {7'h0, kind, b[2], b[1], b[0]};
    for (int i = 0; i < 7; i++) begin
      w[i+1] = {d[4*i+3], d[4*i+2], d[4*i+1], d[4*i]};
    end
    for (int i = 0; i < 8; i++) begin
      if (aud) begin
        audQ.push_back({1'b0, w[i]});
      end else if (typ != TYPE_NULL && !bad) begin
        swQ.push_back({i == 0, w[i]});
      end
    end
    endExp += aud;
    if (aud) begin
      badQ.push_back(bad);
    end
    eccExp += (bad && typ != TYPE_NULL);
    for (int k = 0; k < 36; k++) begin
      @(posedge ref_clk);
      if ($urandom_range(3) == 0) begin
        pktValid <= 1'b0;
        @(posedge ref_clk);
      end
      pktValid <= 1'b1;
      pktSop <= (k == 0);
      pktByte <= b[k];
    end
    @(posedge ref_clk);
    pktValid <= 1'b0;
    pktSop <= 1'b0;
    repeat (30) @(posedge ref_clk);
  endtask
  task automatic ddc(logic [6:0] sl, logic [7:0] off);
    logic [1:0] nv;
    nv = curVer;
    if (sl == PROT_SLAVE && off <= V14_HI) begin
      nv = 2'h1;
    end else if (sl == PROT_SLAVE && off >= V22_LO && off <= V22_HI) begin
      nv = 2'h2;
    end
    irqExp += (nv != curVer);
    curVer = nv;
    @(posedge ref_clk);
    ddcValid <= 1'b1;
    ddcSlave <= sl;
    ddcOffset <= off;
    @(posedge ref_clk);
    ddcValid <= 1'b0;
    repeat (10) @(posedge ref_clk);
    check("activeVer", activeVer, curVer);
  endtask
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    void'($urandom(32'hBE33));
    decKey <= 24'($urandom);
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check("activeVer", activeVer, 0);
    for (int t = 0; t < 19; t++) begin
      send_pkt(t < 11 ? 8'(t) : 8'h75 + 8'(t), 0);
    end
    send_pkt(INFOFRAME_BASE + 8'h02, 1);
    send_pkt(TYPE_HBR, 1);
    send_pkt(TYPE_NULL, 1);
    send_pkt(TYPE_GAMUT, 0);
    ddc(PROT_SLAVE, V14_HI);
    ddc(PROT_SLAVE, 8'h10);
    ddc(PROT_SLAVE, V22_LO);
    ddc(PROT_SLAVE, 8'h48);
    ddc(7'h75, 8'h00);
    ddc(PROT_SLAVE, V14_LO);
    ddc(PROT_SLAVE, V22_HI);
    for (int i = 0; i < 60; i++) begin
      @(posedge ref_clk);
      avValid <= 1'($urandom);
      avData <= 24'($urandom);
      avLast <= (i % 15 == 14);
      if (avValid) begin
        vidQ.push_back({8'h00, avLast, avData ^ decKey});
      end
    end
    @(posedge ref_clk);
    // the last word is taken at this edge too
    if (avValid) begin
      vidQ.push_back({8'h00, avLast, avData ^ decKey});
    end
    avValid <= 1'b0;
    repeat (20) @(posedge ref_clk);
    check("eccErr count", eccSeen, eccExp);
    check("audEnd count", endSeen, endExp);
    check("detect count", irqSeen, irqExp);
    check("left over", audQ.size() + swQ.size() + vidQ.size(), 0);
    close_out();
  end
endmodule // tb

/* File: verilog/hrx_control_end.sv */
// control end: drains the packet queue, switches and runs the decryptors
`timescale 1ns/10ps
module hrx_control_end import hrx_pkg::*; #(
  parameter hrx_prot_t PROT_MODE = HRX_PROT_BOTH,
  parameter int AVW = 24
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [AVW-1:0] decKey,
  output logic swValid,
  output logic [31:0] swWord,
  output logic swHeader,
  output logic swInfoFrame,
  output logic [1:0] activeVer,
  hrx_link_if.host lnk
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    HC_IDLE = 3'b000,
    HC_POP = 3'b001,
    HC_TAKE = 3'b010,
    HC_RST = 3'b011,
    HC_EN = 3'b100
  } hrx_hc_state_t;

  typedef struct packed {
    hrx_hc_state_t fsm;
    logic [3:0] left;
    logic first;
    logic popReq;
    logic swValid;
    logic [31:0] swWord;
    logic swHeader;
    logic swInfoFrame;
    logic detAck;
    logic dec14En;
    logic dec22En;
    logic decRst;
    logic [1:0] pendVer;
    logic ingValid;
    logic [AVW-1:0] ingData;
    logic ingLast;
  } hrx_host_t;

  hrx_host_t st_r;
  hrx_host_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.popReq = 1'b0;
    st_nxt.swValid = 1'b0;
    st_nxt.detAck = 1'b0;
    st_nxt.decRst = 1'b0;
    unique case (st_r.fsm)
      HC_IDLE: begin
        if (lnk.detIrq) begin
          st_nxt.pendVer = lnk.detVer;
          st_nxt.detAck = 1'b1;
          st_nxt.fsm = HC_RST;
        end else if (lnk.auxPending) begin
          st_nxt.popReq = 1'b1; // R06
          st_nxt.left = PKT_WORDS;
          st_nxt.first = 1'b1;
          st_nxt.fsm = HC_POP;
        end
      end
      HC_POP: begin
        // request stands this cycle, its word lands at the closing edge
        st_nxt.fsm = HC_TAKE;
      end
      HC_TAKE: begin
        // popped word is on the link one cycle after the request
        st_nxt.swValid = 1'b1;
        st_nxt.swWord = lnk.popData;
        st_nxt.swHeader = st_r.first;
        if (st_r.first) begin
          st_nxt.swInfoFrame = lnk.popData[31:24] == KIND_INFOFRAME; // R06
        end
        st_nxt.first = 1'b0;
        st_nxt.left = st_r.left - 4'h1;
        if (st_r.left == 4'h1) begin
          st_nxt.fsm = HC_IDLE;
        end else begin
          st_nxt.popReq = 1'b1;
          st_nxt.fsm = HC_POP;
        end
      end
      HC_RST: begin
        // both decryptors off and in reset before the new one starts
        st_nxt.dec14En = 1'b0; // R16
        st_nxt.dec22En = 1'b0;
        st_nxt.decRst = 1'b1;
        st_nxt.fsm = HC_EN;
      end
      HC_EN: begin
        st_nxt.dec14En = st_r.pendVer == HRX_PROT_V14; // R16
        st_nxt.dec22En = st_r.pendVer == HRX_PROT_V22;
        st_nxt.fsm = HC_IDLE;
      end
      default: begin
        st_nxt.fsm = HC_IDLE;
      end
    endcase
    // stand-in decryptor: key mask applied while one is enabled
    st_nxt.ingValid = lnk.egrValid && (st_r.dec14En || st_r.dec22En);
    st_nxt.ingData = lnk.egrData ^ decKey;
    st_nxt.ingLast = lnk.egrLast;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r <= '0;
      st_r.fsm <= HC_IDLE;
      st_r.dec14En <= PROT_MODE == HRX_PROT_V14; // R17
      st_r.dec22En <= PROT_MODE == HRX_PROT_V22;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign swValid = st_r.swValid;
  assign swWord = st_r.swWord;
  assign swHeader = st_r.swHeader;
  assign swInfoFrame = st_r.swInfoFrame;
  assign activeVer = {st_r.dec22En, st_r.dec14En};
  assign lnk.popReq = st_r.popReq;
  assign lnk.detAck = st_r.detAck;
  assign lnk.dec14En = st_r.dec14En;
  assign lnk.dec22En = st_r.dec22En;
  assign lnk.decRst = st_r.decRst;
  assign lnk.ingValid = st_r.ingValid;
  assign lnk.ingData = st_r.ingData;
  assign lnk.ingLast = st_r.ingLast;
endmodule // hrx_control_end

/* File: verilog/hrx_dispatch_end.sv */
// receive end: packet sorting, software queue, protection path and detect
`timescale 1ns/10ps
// Overview of operation
// R01: null packets dropped silently
// R02: audio packet types go to audio output
// R03: other packets queued for software with interrupt
// R04: 0x80 plus type marked as infoframe
// R05: whole packet queued before interrupt raised
// R06: software pops packet, reads header first
// R07: packet is 4 header plus 32 body bytes
// R08: parity checked here, software sees data only
// R09: checksum sum excludes parity bytes
// R10: build option none, 1.4, 2.2 or both
// R11: encrypted data leaves toward active decryptor
// R12: decrypted data returns, goes to video output
// R13: watch channel accesses to slave 0x74
// R14: low offsets mean 1.4, high mean 2.2
// R15: detection event raises interrupt
// R16: software resets both, enables detected one
// R17: single version needs no detection
// R18: only a changed version counts as event
module hrx_dispatch_end import hrx_pkg::*; #(
  parameter hrx_prot_t PROT_MODE = HRX_PROT_BOTH,
  parameter int AVW = 24,
  parameter int AW = 6
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic pktValid,
  input wire logic pktSop,
  input wire logic [7:0] pktByte,
  input wire logic ddcValid,
  input wire logic [6:0] ddcSlave,
  input wire logic [7:0] ddcOffset,
  input wire logic avValid,
  input wire logic [AVW-1:0] avData,
  input wire logic avLast,
  output logic audValid,
  output logic [31:0] audWord,
  output logic audEnd,
  output logic audBad,
  output logic vidValid,
  output logic [AVW-1:0] vidData,
  output logic vidLast,
  output logic eccErr,
  output logic queueOvf,
  hrx_link_if.dev lnk
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [5:0] idx;
    hrx_route_t route;
    logic eccOk;
    logic [7:0] ecc;
    logic [31:0] word;
    logic [AW:0] swp;
    logic [AW:0] cwp;
    logic [AW:0] rp;
    logic [31:0] popData;
    logic auxPending;
    logic audValid;
    logic [31:0] audWord;
    logic audEnd;
    logic audBad;
    logic eccErr;
    logic queueOvf;
    logic [1:0] detVer;
    logic detIrq;
    logic egrValid;
    logic [AVW-1:0] egrData;
    logic egrLast;
    logic vidValid;
    logic [AVW-1:0] vidData;
    logic vidLast;
  } hrx_dev_t;

  hrx_dev_t st_r;
  hrx_dev_t st_nxt;
  logic [31:0] mem [0:(1<<AW)-1];
  logic memWr;

  // one byte through the parity generator, lsb first
  function automatic logic [7:0] eccStep(input logic [7:0] e,
                                         input logic [7:0] d);
    logic [7:0] r;
    logic fb;
    r = e;
    for (int i = 0; i < 8; i++) begin
      fb = d[i] ^ r[0];
      r = {1'b0, r[7:1]};
      if (fb) begin
        r = r ^ ECC_POLY;
      end
    end
    return r;
  endfunction

  function automatic logic isAudio(input logic [7:0] t);
    return (t == TYPE_ACR) || (t == TYPE_AUDIO) || (t == TYPE_ONEBIT) ||
           (t == TYPE_DST) || (t == TYPE_HBR);
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [5:0] i;
    logic [5:0] s;
    logic [4:0] pb;
    logic [1:0] lane;
    logic isData;
    logic wr;
    logic [AW:0] used;
    logic [1:0] ver;
    i = pktSop ? 6'h00 : st_r.idx;
    s = i - 6'h04;
    pb = 5'h00;
    lane = 2'h0;
    isData = 1'b0;
    wr = 1'b0;
    used = st_r.swp - st_r.rp;
    ver = 2'h0;
    st_nxt = st_r;
    memWr = 1'b0;
    st_nxt.audValid = 1'b0;
    st_nxt.audEnd = 1'b0;
    st_nxt.eccErr = 1'b0;
    st_nxt.queueOvf = 1'b0;
    if (pktValid) begin
      st_nxt.idx = (i == PKT_LAST) ? 6'h00 : i + 6'h01; // R07
      if (i < HDR_ECC_IDX) begin
        isData = 1'b1;
        lane = i[1:0];
      end else if (i > HDR_ECC_IDX && s[2:0] != SUB_ECC_POS) begin
        isData = 1'b1;
        pb = ({2'h0, s[5:3]} * 5'h07) + {2'h0, s[2:0]};
        lane = pb[1:0];
      end
      if (i == 6'h00) begin
        st_nxt.eccOk = 1'b1;
        st_nxt.swp = st_r.cwp;
        used = st_r.cwp - st_r.rp;
        if (pktByte == TYPE_NULL) begin
          st_nxt.route = HRX_RT_DROP; // R01
        end else if (isAudio(pktByte)) begin
          st_nxt.route = HRX_RT_AUDIO; // R02
        end else if (used <= (AW+1)'((1 << AW) - PKT_WORDS)) begin
          st_nxt.route = HRX_RT_SOFT; // R03
        end else begin
          st_nxt.route = HRX_RT_DROP;
          st_nxt.queueOvf = 1'b1;
        end
      end
      if (isData) begin
        st_nxt.ecc = eccStep((i == 6'h00) ? 8'h00 : st_r.ecc, pktByte); // R08
        if (lane == 2'h0) begin
          st_nxt.word = {24'h000000, pktByte};
        end else begin
          st_nxt.word = st_r.word | ({24'h000000, pktByte} << {lane, 3'h0});
        end
        if (i == HDR_LAST_IDX) begin
          // byte 3 of the header word carries the kind, not the parity
          st_nxt.word[31:24] = ((st_r.word[7:0] & 8'hF8) == INFOFRAME_BASE)
                               ? KIND_INFOFRAME : KIND_OTHER; // R04
          wr = 1'b1;
        end else if (i > HDR_ECC_IDX && lane == 2'h3) begin
          wr = 1'b1;
        end
      end else begin
        // parity bytes never reach software or the audio words
        st_nxt.ecc = 8'h00; // R09
        if (st_r.ecc != pktByte) begin
          st_nxt.eccOk = 1'b0; // R08
        end
      end
      if (wr && st_nxt.route == HRX_RT_SOFT) begin
        memWr = 1'b1;
        st_nxt.swp = st_r.swp + 1'b1;
      end
      if (wr && st_nxt.route == HRX_RT_AUDIO) begin
        st_nxt.audValid = 1'b1; // R02
        st_nxt.audWord = st_nxt.word;
      end
      if (i == PKT_LAST) begin
        st_nxt.eccErr = ~st_nxt.eccOk && st_r.route != HRX_RT_DROP;
        if (st_r.route == HRX_RT_AUDIO) begin
          st_nxt.audEnd = 1'b1;
          st_nxt.audBad = ~st_nxt.eccOk;
        end
        if (st_r.route == HRX_RT_SOFT && st_nxt.eccOk) begin
          st_nxt.cwp = st_r.swp; // R05
        end
      end
    end
    // software pops one word per request, header word first
    if (lnk.popReq && st_r.rp != st_r.cwp) begin
      st_nxt.popData = mem[st_r.rp[AW-1:0]]; // R06
      st_nxt.rp = st_r.rp + 1'b1;
    end
    st_nxt.auxPending = st_nxt.cwp != st_nxt.rp; // R03
    // protection version detect, only with both decryptors present
    if (lnk.detAck) begin
      st_nxt.detIrq = 1'b0;
    end
    if (PROT_MODE == HRX_PROT_BOTH && ddcValid &&
        ddcSlave == PROT_SLAVE) begin // R13
      if (ddcOffset >= V14_LO && ddcOffset <= V14_HI) begin
        ver = HRX_PROT_V14; // R14
      end else if (ddcOffset >= V22_LO && ddcOffset <= V22_HI) begin
        ver = HRX_PROT_V22; // R14
      end
      if (ver != 2'h0 && ver != st_r.detVer) begin // R18
        st_nxt.detVer = ver;
        st_nxt.detIrq = 1'b1; // R15
      end
    end
    // audiovisual path through the decryptors, or straight to video output when built with none
    if (PROT_MODE == HRX_PROT_NONE) begin // R10
      st_nxt.egrValid = 1'b0;
      st_nxt.vidValid = avValid;
      st_nxt.vidData = avData;
      st_nxt.vidLast = avLast;
    end else begin
      st_nxt.egrValid = avValid; // R11
      st_nxt.egrData = avData;
      st_nxt.egrLast = avLast;
      st_nxt.vidValid = lnk.ingValid; // R12
      st_nxt.vidData = lnk.ingData;
      st_nxt.vidLast = lnk.ingLast;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r <= '0;
      st_r.route <= HRX_RT_DROP;
      // a single built-in version is reported from reset, no switching
      st_r.detVer <= (PROT_MODE == HRX_PROT_BOTH) ? 2'h0 : PROT_MODE; // R17
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (memWr) begin
      mem[st_r.swp[AW-1:0]] <= st_nxt.word;
    end
  end

  assign audValid = st_r.audValid;
  assign audWord = st_r.audWord;
  assign audEnd = st_r.audEnd;
  assign audBad = st_r.audBad;
  assign vidValid = st_r.vidValid;
  assign vidData = st_r.vidData;
  assign vidLast = st_r.vidLast;
  assign eccErr = st_r.eccErr;
  assign queueOvf = st_r.queueOvf;
  assign lnk.auxPending = st_r.auxPending;
  assign lnk.popData = st_r.popData;
  assign lnk.detIrq = st_r.detIrq;
  assign lnk.detVer = st_r.detVer;
  assign lnk.egrValid = st_r.egrValid;
  assign lnk.egrData = st_r.egrData;
  assign lnk.egrLast = st_r.egrLast;
endmodule // hrx_dispatch_end

/* File: verilog/hrx_link_if.sv */
// link between the receive dispatch end and the control/decrypt end
`timescale 1ns/10ps
interface hrx_link_if #(parameter int AVW = 24);
  logic auxPending;
  logic popReq;
  logic [31:0] popData;
  logic detIrq;
  logic [1:0] detVer;
  logic detAck;
  logic dec14En;
  logic dec22En;
  logic decRst;
  logic egrValid;
  logic [AVW-1:0] egrData;
  logic egrLast;
  logic ingValid;
  logic [AVW-1:0] ingData;
  logic ingLast;
  modport dev (
    output auxPending, popData, detIrq, detVer, egrValid, egrData, egrLast,
    input popReq, detAck, dec14En, dec22En, decRst, ingValid, ingData,
    input ingLast
  );
  modport host (
    input auxPending, popData, detIrq, detVer, egrValid, egrData, egrLast,
    output popReq, detAck, dec14En, dec22En, decRst, ingValid, ingData,
    output ingLast
  );
endinterface

/* File: verilog/hrx_pkg.sv */
// shared constants and types for the aux dispatch / protection detect ends
package hrx_pkg;
  // ------------------------------------------------------------
  // packet header type codes
  // ------------------------------------------------------------
  localparam logic [7:0] TYPE_NULL = 8'h00;
  localparam logic [7:0] TYPE_ACR = 8'h01;
  localparam logic [7:0] TYPE_AUDIO = 8'h02;
  localparam logic [7:0] TYPE_GCP = 8'h03;
  localparam logic [7:0] TYPE_ONEBIT = 8'h07;
  localparam logic [7:0] TYPE_DST = 8'h08;
  localparam logic [7:0] TYPE_HBR = 8'h09;
  localparam logic [7:0] TYPE_GAMUT = 8'h0A;
  localparam logic [7:0] INFOFRAME_BASE = 8'h80;
  localparam logic [7:0] INFOFRAME_MAX = 8'h07;
  // ------------------------------------------------------------
  // packet layout
  // ------------------------------------------------------------
  localparam logic [5:0] PKT_LAST = 6'h23;
  localparam logic [5:0] HDR_ECC_IDX = 6'h03;
  localparam logic [5:0] HDR_LAST_IDX = 6'h02;
  localparam logic [2:0] SUB_ECC_POS = 3'h7;
  localparam logic [3:0] PKT_WORDS = 4'h8;
  localparam logic [7:0] ECC_POLY = 8'h83;
  // kind code placed in header byte 3 of a queued packet
  localparam logic [7:0] KIND_OTHER = 8'h00;
  localparam logic [7:0] KIND_INFOFRAME = 8'h01;
  // ------------------------------------------------------------
  // protection slave on the display data channel
  // ------------------------------------------------------------
  localparam logic [6:0] PROT_SLAVE = 7'h74;
  localparam logic [7:0] V14_LO = 8'h00;
  localparam logic [7:0] V14_HI = 8'h44;
  localparam logic [7:0] V22_LO = 8'h50;
  localparam logic [7:0] V22_HI = 8'hC0;

  typedef enum logic [1:0] {
    HRX_PROT_NONE = 2'b00,
    HRX_PROT_V14 = 2'b01,
    HRX_PROT_V22 = 2'b10,
    HRX_PROT_BOTH = 2'b11
  } hrx_prot_t;

  typedef enum logic [1:0] {
    HRX_RT_DROP = 2'b00,
    HRX_RT_AUDIO = 2'b01,
    HRX_RT_SOFT = 2'b10
  } hrx_route_t;
endpackage
